// ---- bce_pkg.sv ----
// package for the balance channel enable bank: register map, reset values, fault carrier
// assumes a single aclk domain and an axi4-lite register bus with 32-bit data
`default_nettype none

package bce_pkg;

   // =====================================================================
   // register map
   // the register is known by its index; its byte address is four times the index
   localparam int unsigned           ADDR_W          = 16;
   localparam int unsigned           NUM_CH          = 7;
   localparam logic [ADDR_W-1:0]     ENABLE_LOW_IDX  = 16'h1002;
   localparam logic [ADDR_W-1:0]     ENABLE_LOW_ADDR = 16'h4008;
   localparam logic [NUM_CH-1:0]     ENABLE_RESET    = 7'h00;
   localparam int unsigned           ENABLE_LSB      = 0;

   // =====================================================================
   // axi response codes
   localparam logic [1:0]            RESP_OKAY       = 2'h0;
   localparam logic [1:0]            RESP_SLVERR     = 2'h2;

   // =====================================================================
   // per-channel fault and timeout indications plus under-voltage check enables, one bit per channel
   typedef struct packed {
      logic [NUM_CH-1:0] over_current;
      logic [NUM_CH-1:0] under_voltage;
      logic [NUM_CH-1:0] uv_check_on;
      logic [NUM_CH-1:0] timer_expired;
   } bce_faults_t;

endpackage

`default_nettype wire

// ---- bce_bank.sv ----
// balance channel enable bank for channels 0 to 6, behind an axi4-lite slave
// assumes fault detectors and channel timers drive the fault struct synchronously to aclk
//
// What this block does
// - an enable bit at one turns balancing on for that channel, channels 0 to 6
// - an enable bit at zero stops balancing and halts that channel's timer
// - all enable bits are zero after reset, so no channel balances
// - an over-current on a channel clears that channel's enable bit
// - an under-voltage with checking enabled clears that channel's enable bit
// - expiry of the channel's balancing timer clears that channel's enable bit
// - software reads and writes the enable bits at bit positions 0 to 6
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module bce_bank (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [bce_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [bce_pkg::ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire bce_pkg::bce_faults_t          faults,
   output logic [bce_pkg::NUM_CH-1:0]         balance_on_ch,
   output logic [bce_pkg::NUM_CH-1:0]         timer_run_ch
);

   // =====================================================================
   // decode
   function automatic logic addr_hit(input logic [bce_pkg::ADDR_W-1:0] a);
      addr_hit = (a[bce_pkg::ADDR_W-1:2] == bce_pkg::ENABLE_LOW_ADDR[bce_pkg::ADDR_W-1:2]);
   endfunction

   logic                         aw_held_reg;
   logic [bce_pkg::ADDR_W-1:0]   aw_addr_reg;
   logic                         w_held_reg;
   logic [31:0]                  w_data_reg;
   logic [3:0]                   w_strb_reg;
   logic [bce_pkg::NUM_CH-1:0]   enable_reg;
   logic [bce_pkg::NUM_CH-1:0]   enable_next;
   logic [bce_pkg::NUM_CH-1:0]   fault_clear;
   logic                         aw_hs;
   logic                         w_hs;
   logic                         ar_hs;
   logic                         do_write;
   logic                         wr_hit;
   logic                         aw_held_next;
   logic                         w_held_next;
   logic                         rvalid_next;

   assign aw_hs    = s_axi_awvalid & s_axi_awready;
   assign w_hs     = s_axi_wvalid & s_axi_wready;
   assign ar_hs    = s_axi_arvalid & s_axi_arready;
   // one write is retired only once the previous response has been taken
   assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   assign wr_hit   = do_write & addr_hit(aw_addr_reg) & w_strb_reg[0];

   assign aw_held_next = (aw_held_reg | aw_hs) & ~do_write;
   assign w_held_next  = (w_held_reg | w_hs) & ~do_write;
   assign rvalid_next  = (s_axi_rvalid & ~s_axi_rready) | ar_hs;

   // =====================================================================
   // write channel capture, address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg   <= 1'b0;
         aw_addr_reg   <= '0;
         s_axi_awready <= 1'b0;
      end else begin
         aw_held_reg   <= aw_held_next;
         s_axi_awready <= ~aw_held_next;
         if (aw_hs) begin
            aw_addr_reg <= s_axi_awaddr;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg   <= 1'b0;
         w_data_reg   <= '0;
         w_strb_reg   <= '0;
         s_axi_wready <= 1'b0;
      end else begin
         w_held_reg   <= w_held_next;
         s_axi_wready <= ~w_held_next;
         if (w_hs) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
      end
   end

   // =====================================================================
   // write response; unmapped addresses answer slverr and change nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= bce_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_hit(aw_addr_reg) ? bce_pkg::RESP_OKAY : bce_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // =====================================================================
   // read channel; bits above channel 6 read zero, they belong elsewhere
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= bce_pkg::RESP_OKAY;
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_rvalid  <= rvalid_next;
         s_axi_arready <= ~rvalid_next;
         if (ar_hs) begin
            if (addr_hit(s_axi_araddr)) begin
               s_axi_rdata <= {25'h0, enable_reg};
               s_axi_rresp <= bce_pkg::RESP_OKAY;
            end else begin
               s_axi_rdata <= '0;
               s_axi_rresp <= bce_pkg::RESP_SLVERR;
            end
         end
      end
   end

   // =====================================================================
   // enable bits
   // under-voltage only counts while its check is on for that channel
   assign fault_clear = faults.over_current
                      | (faults.under_voltage & faults.uv_check_on)
                      | faults.timer_expired;

   always_comb begin
      enable_next = enable_reg;
      if (wr_hit) begin
         enable_next = s_axi_wdata_field(w_data_reg);
      end
      // clear applied last so a fault beats a same-cycle software set
      enable_next = enable_next & ~fault_clear;
   end

   function automatic logic [bce_pkg::NUM_CH-1:0] s_axi_wdata_field(input logic [31:0] d);
      s_axi_wdata_field = d[bce_pkg::ENABLE_LSB +: bce_pkg::NUM_CH];
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_reg    <= bce_pkg::ENABLE_RESET;
         balance_on_ch <= bce_pkg::ENABLE_RESET;
         timer_run_ch  <= bce_pkg::ENABLE_RESET;
      end else begin
         enable_reg    <= enable_next;
         balance_on_ch <= enable_next;
         // a disabled channel holds its timer still
         timer_run_ch  <= enable_next;
      end
   end

   // =====================================================================
   // checks
   chk_reset_clears_enables: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (enable_reg == '0 && balance_on_ch == '0))
      else $error("enable bits not zero after reset");

   chk_overcurrent_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      (faults.over_current != '0) |=>
      ((balance_on_ch & $past(faults.over_current)) == '0))
      else $error("over-current did not clear enable");

   chk_undervoltage_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      ((faults.under_voltage & faults.uv_check_on) != '0) |=>
      ((enable_reg & $past(faults.under_voltage & faults.uv_check_on)) == '0))
      else $error("checked under-voltage did not clear enable");

   chk_uv_unchecked_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
      (!wr_hit && faults.over_current == '0 && faults.timer_expired == '0 &&
       (faults.under_voltage & faults.uv_check_on) == '0) |=> $stable(enable_reg))
      else $error("enable changed without cause");

   chk_timeout_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      (faults.timer_expired != '0) |=>
      ((timer_run_ch & $past(faults.timer_expired)) == '0))
      else $error("timer expiry did not clear enable");

   chk_write_sets_bits: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_hit && fault_clear == '0) |=>
      (balance_on_ch == $past(w_data_reg[6:0])))
      else $error("write did not reach balance outputs");

   chk_clear_beats_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_hit && (w_data_reg[6:0] & fault_clear) != '0) |=>
      ((enable_reg & $past(fault_clear)) == '0))
      else $error("software set won over fault clear");

   chk_timer_follows_enable: assert property (@(posedge aclk) disable iff (!aresetn)
      (timer_run_ch == balance_on_ch) && (balance_on_ch == enable_reg))
      else $error("timer runs on a disabled channel");

   chk_read_returns_enables: assert property (@(posedge aclk) disable iff (!aresetn)
      (ar_hs && addr_hit(s_axi_araddr)) |=>
      (s_axi_rvalid && s_axi_rdata == {25'h0, $past(enable_reg)} &&
       s_axi_rresp == bce_pkg::RESP_OKAY))
      else $error("read data differs from enable bits");

   chk_write_answered: assert property (@(posedge aclk) disable iff (!aresetn)
      (aw_held_reg && w_held_reg) |-> ##[0:2] s_axi_bvalid)
      else $error("write response missing");

   cov_write_enable: cover property (@(posedge aclk) disable iff (!aresetn)
      wr_hit && w_data_reg[6:0] != '0);
   cov_read_enable: cover property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && s_axi_rready && s_axi_rdata != '0);
   cov_fault_on_active: cover property (@(posedge aclk) disable iff (!aresetn)
      (enable_reg & fault_clear) != '0);
   cov_write_fault_clash: cover property (@(posedge aclk) disable iff (!aresetn)
      wr_hit && (w_data_reg[6:0] & fault_clear) != '0);

endmodule

`default_nettype wire

// ---- bce_bank_dummy_end.sv ----
// intentionally empty
`default_nettype none
`default_nettype wire

// ---- bce_bank_tb.sv ----
// self-checking bench for the balance channel enable bank: axi4-lite host tasks, fault pulses
// assumes bce_pkg and bce_bank are compiled first; one 100 MHz clock, no partner model
`timescale 1ns/1ps
`default_nettype none

module bce_bank_tb;
   // =====================================================================
   // signals
   logic                 aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                 s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                 s_axi_rvalid, s_axi_rready;
   logic [15:0]          s_axi_awaddr, s_axi_araddr, seed;
   logic [31:0]          s_axi_wdata, s_axi_rdata, rd, d;
   logic [3:0]           s_axi_wstrb;
   logic [1:0]           s_axi_bresp, s_axi_rresp, resp;
   bce_pkg::bce_faults_t faults;
   logic [6:0]           balance_on_ch, timer_run_ch, en_exp, m, c;
   int                   n_mismatch, n_checks, cyc;

   bce_bank dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .faults(faults), .balance_on_ch(balance_on_ch),
      .timer_run_ch(timer_run_ch));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // =====================================================================
   // helpers
   function automatic logic [15:0] lfsr_step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // channels that a fault pulse of kind k must knock out
   function automatic logic [6:0] fault_mask(input int k, input logic [6:0] f, input logic [6:0] u);
      return (k == 1) ? (f & u) : f;
   endfunction

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // readies are sampled at the falling edge so the request moves only after a rising one
   task axi_write(input logic [15:0] a, input logic [31:0] wd, input logic [3:0] s);
      logic aw_done, w_done, ta, tw;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(negedge aclk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         @(posedge aclk);
         if (ta === 1'b1 && !aw_done) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (tw === 1'b1 && !w_done) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask

   task axi_read(input logic [15:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask

   task reg_check;
      @(negedge aclk);
      chk("balance_on_ch", {25'h0, en_exp}, {25'h0, balance_on_ch});
      chk("timer_run_ch", {25'h0, en_exp}, {25'h0, timer_run_ch});
      axi_read(bce_pkg::ENABLE_LOW_ADDR);
      chk("rdata", {25'h0, en_exp}, rd);
      chk("rresp", {30'h0, bce_pkg::RESP_OKAY}, {30'h0, resp});
   endtask

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         print_verdict;
      end
   end

   // =====================================================================
   // main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      faults = '0;
      {n_mismatch, n_checks, cyc} = '0;
      seed = 16'h75f8;
      en_exp = 7'h00;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      reg_check;
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         seed = lfsr_step(seed);
         d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : {seed, ~seed};
         axi_write(bce_pkg::ENABLE_LOW_ADDR, d, 4'hf);
         en_exp = d[6:0];
         chk("bresp", {30'h0, bce_pkg::RESP_OKAY}, {30'h0, resp});
         reg_check;
      end
      axi_write(bce_pkg::ENABLE_LOW_ADDR, {25'h0, ~en_exp}, 4'he);
      chk("bresp no lane", {30'h0, bce_pkg::RESP_OKAY}, {30'h0, resp});
      reg_check;
      axi_write(bce_pkg::ENABLE_LOW_IDX, {25'h0, ~en_exp}, 4'hf);
      chk("bresp unmapped", {30'h0, bce_pkg::RESP_SLVERR}, {30'h0, resp});
      axi_read(bce_pkg::ENABLE_LOW_IDX);
      chk("rdata unmapped", 32'h0, rd);
      reg_check;
      $display("test register access done");
      for (int k = 0; k < 3; k++) begin
         for (int j = 0; j < 4; j++) begin
            axi_write(bce_pkg::ENABLE_LOW_ADDR, 32'h7f, 4'hf);
            seed = lfsr_step(seed);
            m = seed[6:0];
            c = seed[13:7];
            @(posedge aclk);
            if (k == 0) faults.over_current <= m;
            if (k == 1) faults.under_voltage <= m;
            if (k == 1) faults.uv_check_on <= c;
            if (k == 2) faults.timer_expired <= m;
            @(posedge aclk);
            faults <= '0;
            en_exp = 7'h7f & ~fault_mask(k, m, c);
            reg_check;
         end
      end
      $display("test fault clears done");
      @(posedge aclk);
      faults.timer_expired <= 7'h05;
      axi_write(bce_pkg::ENABLE_LOW_ADDR, 32'h7f, 4'hf);
      @(posedge aclk);
      faults <= '0;
      en_exp = 7'h7a;
      reg_check;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      en_exp = 7'h00;
      repeat (2) @(posedge aclk);
      reg_check;
      $display("test clear priority and second reset done");
      print_verdict;
   end
endmodule

`default_nettype wire
